// file: design/eac_checker.sv
`timescale 1ns/1ns
`include "eac_defs.svh"
// Notes on behaviour
// - fetch from inside an enclave to an address outside its range gives GP(0).
// - shadow-stack load or store from inside to outside the range gives GP(0).
// - regular, thread-control, trimmed pages only at allocation address, else enclave PF.
// - direct accesses checked against page metadata; failure gives enclave PF.
// - target page must belong to the enclave currently running.
// - write, read, fetch need write, read, execute permission respectively.
// - shadow-stack load and store need a shadow-stack page type.
// - ordinary writes to either shadow-stack page type are rejected.
// - control-structure, thread-control, version-array, trimmed pages are never directly accessed.
// - page_state_a, pending or page_state_b pages reject direct accesses.
// - only regular pages grant read, write or execute permission.
// - entry and resume fault GP(0) on a usable code/data/extra/stack segment with nonzero base.
// - entry saves outside thread-local segments, loads them from thread-control structure.
// - exit and asynchronous exit restore thread-local segments to their entry values.
// - asynchronous exit stores enclave segments to the frame; resume reloads them from it.
// - data access straddling the range splits; only its inside part is checked against page metadata.
// - fetch straddling the range boundary gives GP for its outside part.
// - explicit operand accesses report segmentation or paging faults at access time.
// - implicit cached-address accesses never raise faults, exits or breakpoints.
// - page bound to control structure on add/augment/reload, unbound on remove/writeback.
// - thread-control and frame addresses cached at entry, dropped on any exit.
// - accesses to protected memory from outside any enclave are altered, not served.
module eac_checker
    import eac_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input eac_req_s REQ,
    output eac_resp_s RESP,
    input eac_op_s OP,
    output logic OP_GP,
    output logic [31:0] SEG_A,
    output logic [31:0] SEG_B,
    output logic FRAME_STORE,
    output logic [31:0] FRAME_SEG_A,
    output logic [31:0] FRAME_SEG_B
);

    // ****************************************
    // registers and helpers
    // ****************************************
    logic [31:0] base_q;
    logic [31:0] limit_q;
    logic [7:0] id_q;
    logic [2:0] bind_sel_q;
    eac_mode_e mode_q;
    logic [31:0] saved_a_q;
    logic [31:0] saved_b_q;
    logic [31:0] tcs_phys_q;
    logic [31:0] ssa_phys_q;
    logic cached_q;
    logic bind_valid_q [`EAC_BIND_DEPTH];
    logic [31:0] bind_phys_q [`EAC_BIND_DEPTH];
    eac_resp_s resp_d;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic is_ss_type(input eac_ptype_e t);
        is_ss_type = (t == EAC_FIRST_SHADOW_STACK_PAGE_TYPE) ||
                     (t == EAC_LATER_SHADOW_STACK_PAGE_TYPE);
    endfunction

    // true when the inside part fails any metadata check
    function automatic logic meta_fail(input eac_meta_s m, input eac_kind_e k,
                                       input logic [19:0] page, input logic [7:0] id);
        logic alias_bad;
        logic perm_bad;
        logic reg_t;
        alias_bad = 1'b0;
        perm_bad = 1'b0;
        reg_t = (m.ptype == EAC_REGULAR_PAGE_TYPE);
        if ((reg_t || m.ptype == EAC_THREAD_CONTROL_PAGE_TYPE ||
             m.ptype == EAC_TRIMMED_PAGE_TYPE) && (m.alloc_page != page)) begin
            alias_bad = 1'b1;
        end
        unique case (k)
            EAC_READ: perm_bad = !(reg_t && m.perm_r);
            EAC_WRITE: perm_bad = !(reg_t && m.perm_w) || is_ss_type(m.ptype);
            EAC_FETCH: perm_bad = !(reg_t && m.perm_x);
            EAC_SS_LOAD, EAC_SS_STORE: perm_bad = !is_ss_type(m.ptype);
            default: perm_bad = 1'b1;
        endcase
        meta_fail = !m.in_protected_page_memory || alias_bad || perm_bad ||
                    (m.owner != id) ||
                    (m.ptype == EAC_CONTROL_STRUCTURE_PAGE_TYPE) ||
                    (m.ptype == EAC_THREAD_CONTROL_PAGE_TYPE) ||
                    (m.ptype == EAC_VERSION_ARRAY_PAGE_TYPE) ||
                    (m.ptype == EAC_TRIMMED_PAGE_TYPE) ||
                    m.page_state_a || m.pending || m.page_state_b;
    endfunction

    // ****************************************
    // register bus
    // ****************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            base_q <= `EAC_RST_BASE;
            limit_q <= `EAC_RST_LIMIT;
            id_q <= `EAC_RST_ID;
            bind_sel_q <= 3'h0;
        end else if (WR) begin
            unique case (ADDR)
                `EAC_OFF_BASE: base_q <= WDATA;
                `EAC_OFF_LIMIT: limit_q <= WDATA;
                `EAC_OFF_ID: id_q <= WDATA[7:0];
                `EAC_OFF_BIND_SEL: bind_sel_q <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            unique case (ADDR)
                `EAC_OFF_BASE: RDATA <= base_q;
                `EAC_OFF_LIMIT: RDATA <= limit_q;
                `EAC_OFF_ID: RDATA <= {24'h0, id_q};
                `EAC_OFF_STATUS: RDATA <= {29'h0, bind_valid_q[bind_sel_q], cached_q,
                                           mode_q == EAC_INSIDE};
                `EAC_OFF_TCS_PHYS: RDATA <= tcs_phys_q;
                `EAC_OFF_SSA_PHYS: RDATA <= ssa_phys_q;
                `EAC_OFF_BIND_SEL: RDATA <= {29'h0, bind_sel_q};
                `EAC_OFF_BIND_PHYS: RDATA <= bind_phys_q[bind_sel_q];
                default: RDATA <= 32'h0;
            endcase
        end else begin
            RDATA <= 32'h0;
        end
    end

    // ****************************************
    // entry, exit and segment handling
    // ****************************************
    logic seg_gp;
    logic entry_ok;
    logic is_entry;
    logic is_exit;
    assign is_entry = OP.valid && mode_q == EAC_OUTSIDE &&
                      (OP.op == EAC_ENCLAVE_ENTER_OP || OP.op == EAC_ENCLAVE_RESUME_OP);
    assign is_exit = OP.valid && mode_q == EAC_INSIDE &&
                     (OP.op == EAC_ENCLAVE_EXIT_OP || OP.op == EAC_ASYNCHRONOUS_EXIT);
    assign seg_gp = |(OP.seg_usable & OP.seg_base_nz);
    assign entry_ok = is_entry && !seg_gp;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_q <= EAC_OUTSIDE;
        end else begin
            unique case (mode_q)
                EAC_OUTSIDE: if (entry_ok) mode_q <= EAC_INSIDE;
                EAC_INSIDE: if (is_exit) mode_q <= EAC_OUTSIDE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OP_GP <= 1'b0;
        end else begin
            OP_GP <= is_entry && seg_gp;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SEG_A <= 32'h0;
            SEG_B <= 32'h0;
            saved_a_q <= 32'h0;
            saved_b_q <= 32'h0;
        end else if (entry_ok) begin
            saved_a_q <= OP.seg_a_outside;
            saved_b_q <= OP.seg_b_outside;
            if (OP.op == EAC_ENCLAVE_RESUME_OP) begin
                SEG_A <= OP.frame_seg_a;
                SEG_B <= OP.frame_seg_b;
            end else begin
                SEG_A <= OP.tcs_seg_a;
                SEG_B <= OP.tcs_seg_b;
            end
        end else if (is_exit) begin
            SEG_A <= saved_a_q;
            SEG_B <= saved_b_q;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FRAME_STORE <= 1'b0;
            FRAME_SEG_A <= 32'h0;
            FRAME_SEG_B <= 32'h0;
        end else begin
            FRAME_STORE <= is_exit && OP.op == EAC_ASYNCHRONOUS_EXIT;
            if (is_exit && OP.op == EAC_ASYNCHRONOUS_EXIT) begin
                FRAME_SEG_A <= SEG_A;
                FRAME_SEG_B <= SEG_B;
            end
        end
    end

    // cached addresses feed implicit accesses only; they are never rechecked
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cached_q <= 1'b0;
            tcs_phys_q <= 32'h0;
            ssa_phys_q <= 32'h0;
        end else if (entry_ok) begin
            cached_q <= 1'b1;
            tcs_phys_q <= OP.tcs_phys;
            ssa_phys_q <= OP.ssa_phys;
        end else if (is_exit) begin
            cached_q <= 1'b0;
            tcs_phys_q <= 32'h0;
            ssa_phys_q <= 32'h0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `EAC_BIND_DEPTH; gi++) begin : g_bind
            logic hit;
            assign hit = OP.valid && OP.page_idx == 3'(gi);
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    bind_valid_q[gi] <= 1'b0;
                    bind_phys_q[gi] <= 32'h0;
                end else if (hit && (OP.op == EAC_PAGE_ADD_OP ||
                                     OP.op == EAC_PAGE_AUGMENT_OP ||
                                     OP.op == EAC_PAGE_RELOAD_PAGE_STATE_A_OP ||
                                     OP.op == EAC_PAGE_RELOAD_UNBLOCKED_OP)) begin
                    bind_valid_q[gi] <= 1'b1;
                    bind_phys_q[gi] <= OP.ctrl_phys;
                end else if (hit && (OP.op == EAC_PAGE_REMOVE_OP ||
                                     OP.op == EAC_PAGE_WRITEBACK_OP)) begin
                    bind_valid_q[gi] <= 1'b0;
                    bind_phys_q[gi] <= 32'h0;
                end
            end
        end
    endgenerate

    // ****************************************
    // access checking
    // ****************************************
    logic [31:0] last_addr;
    logic start_in;
    logic end_in;
    logic in_enc;
    assign last_addr = REQ.addr + {29'h0, REQ.size_m1};
    assign start_in = in_range(REQ.addr, base_q, limit_q);
    assign end_in = in_range(last_addr, base_q, limit_q);
    assign in_enc = mode_q == EAC_INSIDE;

    always_comb begin
        logic [19:0] in_page;
        in_page = start_in ? REQ.addr[31:`EAC_PAGE_LSB] : last_addr[31:`EAC_PAGE_LSB];
        resp_d = '0;
        resp_d.valid = REQ.valid;
        resp_d.verdict = EAC_ALLOW;
        if (!REQ.valid || REQ.implicit_acc) begin
            resp_d.verdict = EAC_ALLOW;
        end else if (REQ.explicit_acc && REQ.lower_fault) begin
            resp_d.verdict = EAC_LOWER;
        end else if (!in_enc) begin
            resp_d.altered = REQ.meta.in_protected_page_memory;
        end else begin
            resp_d.split = start_in != end_in;
            if (REQ.kind == EAC_FETCH && !(start_in && end_in)) begin
                resp_d.verdict = EAC_GP;
            end else if ((REQ.kind == EAC_SS_LOAD || REQ.kind == EAC_SS_STORE) &&
                         !(start_in && end_in)) begin
                resp_d.verdict = EAC_GP;
            end else if ((start_in || end_in) && meta_fail(REQ.meta, REQ.kind, in_page, id_q)) begin
                resp_d.verdict = EAC_PF;
                resp_d.page_fault_enclave_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESP <= '0;
        end else begin
            RESP <= resp_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_fetch_out_gp:
    assert property (REQ.valid && !REQ.implicit_acc && !REQ.explicit_acc && in_enc &&
                     REQ.kind == EAC_FETCH && !start_in |=> RESP.verdict == EAC_GP)
    else $error("fetch outside range not faulted");

    a_ss_out_gp:
    assert property (REQ.valid && !REQ.implicit_acc && !REQ.explicit_acc && in_enc &&
                     REQ.kind == EAC_SS_STORE && !start_in && !end_in
                     |=> RESP.verdict == EAC_GP)
    else $error("shadow stack outside range not faulted");

    a_pf_flag_set:
    assert property (RESP.valid && RESP.verdict == EAC_PF |-> RESP.page_fault_enclave_flag)
    else $error("page fault without enclave flag");

    a_owner_check:
    assert property (REQ.valid && !REQ.implicit_acc && !REQ.explicit_acc && in_enc &&
                     start_in && end_in && REQ.meta.owner != id_q
                     |=> RESP.verdict == EAC_PF)
    else $error("foreign page not rejected");

    a_state_check:
    assert property (REQ.valid && !REQ.implicit_acc && !REQ.explicit_acc && in_enc &&
                     start_in && end_in && REQ.kind == EAC_READ && REQ.meta.pending
                     |=> RESP.verdict == EAC_PF)
    else $error("pending page not rejected");

    a_seg_entry_gp:
    assert property (is_entry && seg_gp |=> OP_GP && mode_q == EAC_OUTSIDE)
    else $error("bad segment base accepted");

    a_seg_restore:
    assert property (is_exit |=> SEG_A == $past(saved_a_q) && SEG_B == $past(saved_b_q))
    else $error("segment not restored on exit");

    a_implicit_quiet:
    assert property (REQ.valid && REQ.implicit_acc |=> RESP.verdict == EAC_ALLOW && RESP.valid)
    else $error("implicit access faulted");

    a_cache_flush:
    assert property (is_exit |=> !cached_q && tcs_phys_q == 32'h0)
    else $error("cached addresses kept after exit");

    a_split_flag:
    assert property (REQ.valid && !REQ.implicit_acc && !REQ.explicit_acc && in_enc &&
                     start_in != end_in |=> RESP.split)
    else $error("split not indicated");

endmodule

// file: design/eac_defs.svh
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

// register offsets (byte addresses)
`define EAC_OFF_BASE 8'h00
`define EAC_OFF_LIMIT 8'h04
`define EAC_OFF_ID 8'h08
`define EAC_OFF_STATUS 8'h0C
`define EAC_OFF_TCS_PHYS 8'h10
`define EAC_OFF_SSA_PHYS 8'h14
`define EAC_OFF_BIND_SEL 8'h18
`define EAC_OFF_BIND_PHYS 8'h1C

// status fields
`define EAC_ST_INSIDE 0
`define EAC_ST_CACHED 1
`define EAC_ST_BOUND 2

// reset values
`define EAC_RST_BASE 32'h0000_0000
`define EAC_RST_LIMIT 32'h0000_0000
`define EAC_RST_ID 8'h00

// sizes
`define EAC_PAGE_LSB 12
`define EAC_BIND_DEPTH 8
`define EAC_BIND_IW 3

`endif

// file: design/eac_pkg.sv
package eac_pkg;

    typedef enum logic [2:0] {
        EAC_FETCH, EAC_READ, EAC_WRITE, EAC_SS_LOAD, EAC_SS_STORE
    } eac_kind_e;

    typedef enum logic [2:0] {
        EAC_REGULAR_PAGE_TYPE, EAC_THREAD_CONTROL_PAGE_TYPE, EAC_TRIMMED_PAGE_TYPE,
        EAC_CONTROL_STRUCTURE_PAGE_TYPE, EAC_VERSION_ARRAY_PAGE_TYPE,
        EAC_FIRST_SHADOW_STACK_PAGE_TYPE, EAC_LATER_SHADOW_STACK_PAGE_TYPE
    } eac_ptype_e;

    typedef enum logic [1:0] {EAC_ALLOW, EAC_GP, EAC_PF, EAC_LOWER} eac_verdict_e;

    typedef enum logic [3:0] {
        EAC_OP_NONE, EAC_ENCLAVE_ENTER_OP, EAC_ENCLAVE_RESUME_OP, EAC_ENCLAVE_EXIT_OP,
        EAC_ASYNCHRONOUS_EXIT, EAC_PAGE_ADD_OP, EAC_PAGE_AUGMENT_OP,
        EAC_PAGE_RELOAD_PAGE_STATE_A_OP, EAC_PAGE_RELOAD_UNBLOCKED_OP,
        EAC_PAGE_REMOVE_OP, EAC_PAGE_WRITEBACK_OP
    } eac_op_e;

    typedef enum {EAC_OUTSIDE, EAC_INSIDE} eac_mode_e;

    // metadata of the page holding the inside part of an access
    typedef struct packed {
        logic in_protected_page_memory;
        logic [7:0] owner;
        eac_ptype_e ptype;
        logic perm_r;
        logic perm_w;
        logic perm_x;
        logic page_state_a;
        logic pending;
        logic page_state_b;
        logic [19:0] alloc_page;
    } eac_meta_s;

    typedef struct packed {
        logic valid;
        eac_kind_e kind;
        logic implicit_acc;
        logic explicit_acc;
        logic lower_fault;
        logic [31:0] addr;
        logic [2:0] size_m1;
        eac_meta_s meta;
    } eac_req_s;

    typedef struct packed {
        logic valid;
        eac_verdict_e verdict;
        logic page_fault_enclave_flag;
        logic split;
        logic altered;
    } eac_resp_s;

    typedef struct packed {
        logic valid;
        eac_op_e op;
        logic [3:0] seg_usable;
        logic [3:0] seg_base_nz;
        logic [31:0] seg_a_outside;
        logic [31:0] seg_b_outside;
        logic [31:0] tcs_seg_a;
        logic [31:0] tcs_seg_b;
        logic [31:0] frame_seg_a;
        logic [31:0] frame_seg_b;
        logic [31:0] tcs_phys;
        logic [31:0] ssa_phys;
        logic [2:0] page_idx;
        logic [31:0] ctrl_phys;
    } eac_op_s;

endpackage

// file: verif/eac_pipe_model.sv
`timescale 1ns/1ns
// ****************************************
// pipeline side: one request per call
// ****************************************
module eac_pipe_model
    import eac_pkg::*;
(
    input wire logic CLK,
    output eac_req_s REQ,
    input eac_resp_s RESP
);
    initial REQ = '0;

    // a gap makes the pipeline slow; released fields turn to their inverse
    // so a stale request can never pass for a fresh one
    task automatic send(input eac_req_s r, input int gap, output eac_resp_s got);
        eac_req_s nx;
        nx = eac_req_s'(~r);
        nx.valid = 1'b0;
        repeat (gap) @(posedge CLK);
        @(posedge CLK);
        REQ <= r;
        @(posedge CLK);
        REQ <= nx;
        #1;
        got = RESP;
    endtask
endmodule

// file: verif/enclave_access_checker_test.sv
`timescale 1ns/1ns
`include "eac_defs.svh"
module enclave_access_checker_test
    import eac_pkg::*;
;
    logic clk, reset_n, wr, rd, op_gp, frame_store, mode_in;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, seg_a, seg_b, frame_seg_a, frame_seg_b;
    logic [31:0] base, lim, id, sa, sb, out_a, out_b, fr_a, fr_b;
    logic [15:0] seed;
    eac_req_s req;
    eac_resp_s resp;
    eac_op_s op_s, ob;
    int error_cnt, n_checks;

    eac_checker dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .REQ(req), .RESP(resp), .OP(op_s), .OP_GP(op_gp),
        .SEG_A(seg_a), .SEG_B(seg_b), .FRAME_STORE(frame_store),
        .FRAME_SEG_A(frame_seg_a), .FRAME_SEG_B(frame_seg_b));
    eac_pipe_model u_pipe (.CLK(clk), .REQ(req), .RESP(resp));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] resp expected %h seen %h", e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // stimulus and reference model
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rnd(output logic [15:0] v);
        seed = lfsr(seed);
        v = seed;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    function automatic eac_meta_s good(input logic [31:0] pa, input eac_kind_e k);
        eac_meta_s m;
        m = '0;
        m.in_protected_page_memory = 1'b1;
        m.owner = id[7:0];
        m.ptype = k >= EAC_SS_LOAD ? EAC_FIRST_SHADOW_STACK_PAGE_TYPE : EAC_REGULAR_PAGE_TYPE;
        m.perm_r = 1'b1;
        m.perm_w = 1'b1;
        m.perm_x = 1'b1;
        m.alloc_page = pa[31:12];
        return m;
    endfunction
    // result packed as {verdict, enclave flag, split, altered}
    function automatic logic [4:0] model(input eac_req_s r);
        logic [31:0] last;
        logic ins, ine, ok, sp;
        last = r.addr + 32'(r.size_m1);
        ins = r.addr >= base && r.addr <= lim;
        ine = last >= base && last <= lim;
        sp = ins != ine;
        ok = r.meta.in_protected_page_memory && r.meta.owner == id[7:0]
            && !(r.meta.page_state_a | r.meta.pending | r.meta.page_state_b);
        if (r.meta.ptype == EAC_REGULAR_PAGE_TYPE)
            ok &= r.meta.alloc_page == (ins ? r.addr[31:12] : last[31:12]);
        if (r.kind >= EAC_SS_LOAD)
            ok &= r.meta.ptype inside {EAC_FIRST_SHADOW_STACK_PAGE_TYPE,
                EAC_LATER_SHADOW_STACK_PAGE_TYPE};
        else
            ok &= r.meta.ptype == EAC_REGULAR_PAGE_TYPE && (r.kind == EAC_FETCH ?
                r.meta.perm_x : r.kind == EAC_READ ? r.meta.perm_r : r.meta.perm_w);
        if (r.implicit_acc) return {EAC_ALLOW, 3'h0};
        if (r.explicit_acc && r.lower_fault) return {EAC_LOWER, 3'h0};
        if (!mode_in) return {EAC_ALLOW, 2'h0, r.meta.in_protected_page_memory};
        if ((r.kind == EAC_FETCH || r.kind >= EAC_SS_LOAD) && !(ins && ine))
            return {EAC_GP, 1'b0, sp, 1'b0};
        if ((ins || ine) && !ok) return {EAC_PF, 1'b1, sp, 1'b0};
        return {EAC_ALLOW, 1'b0, sp, 1'b0};
    endfunction
    task automatic acc(input eac_req_s r, input int gap);
        eac_resp_s g;
        logic [4:0] e, m;
        e = model(r);
        // split and altered are left open for implicit and lower-fault accesses
        m = (r.implicit_acc || (r.explicit_acc && r.lower_fault)) ? 5'h1C : 5'h1F;
        u_pipe.send(r, gap, g);
        chk("resp_valid", 32'h1, {31'h0, g.valid});
        chk_resp(e & m, {g.verdict, g.page_fault_enclave_flag, g.split, g.altered} & m);
    endtask
    task automatic dir(input eac_kind_e k, input logic [31:0] a, input logic [2:0] s);
        eac_req_s r;
        r = '0;
        r.valid = 1'b1;
        r.kind = k;
        r.addr = a;
        r.size_m1 = s;
        r.meta = good(a < base ? a + 32'(s) : a, k);
        acc(r, 1);
    endtask
    task automatic rand_req(output eac_req_s r);
        logic [15:0] a, b, c;
        rnd(a);
        rnd(b);
        rnd(c);
        r = '0;
        r.valid = 1'b1;
        r.addr = 32'h3FF0 + {16'h0, a} % 32'h4020;
        r.size_m1 = b[2:0];
        r.kind = eac_kind_e'(b[15:8] % 8'h05);
        r.implicit_acc = c[0] & c[1];
        r.explicit_acc = c[2];
        r.lower_fault = c[3] & c[4];
        r.meta = good(r.addr < base ? r.addr + 32'(b[2:0]) : r.addr, r.kind);
        if (b[3] & c[12]) r.meta.ptype = eac_ptype_e'(c[7:5] % 3'h7);
        r.meta.perm_r &= !(b[4] & b[5]);
        r.meta.perm_w &= !(b[5] & b[6]);
        r.meta.perm_x &= !(b[6] & b[7]);
        r.meta.owner ^= {7'h0, c[8] & c[9]};
        r.meta.page_state_a = c[10] & c[11] & a[0];
        r.meta.pending = c[10] & c[11] & a[1];
        r.meta.page_state_b = c[10] & c[11] & a[2];
        r.meta.alloc_page ^= {19'h0, b[7] & c[13]};
        r.meta.in_protected_page_memory = !(c[14] & c[15]);
    endtask
    task automatic run_op(input eac_op_e k, input logic [3:0] us, input logic [3:0] nz);
        logic gp, fs;
        gp = 1'b0;
        fs = 1'b0;
        ob.valid = 1'b1;
        ob.op = k;
        ob.seg_usable = us;
        ob.seg_base_nz = nz;
        if (!mode_in && (k == EAC_ENCLAVE_ENTER_OP || k == EAC_ENCLAVE_RESUME_OP)) begin
            gp = (us & nz) != 4'h0;
            if (!gp) begin
                out_a = ob.seg_a_outside;
                out_b = ob.seg_b_outside;
                sa = k == EAC_ENCLAVE_ENTER_OP ? ob.tcs_seg_a : ob.frame_seg_a;
                sb = k == EAC_ENCLAVE_ENTER_OP ? ob.tcs_seg_b : ob.frame_seg_b;
                mode_in = 1'b1;
            end
        end else if (mode_in && (k == EAC_ENCLAVE_EXIT_OP || k == EAC_ASYNCHRONOUS_EXIT)) begin
            fs = k == EAC_ASYNCHRONOUS_EXIT;
            fr_a = sa;
            fr_b = sb;
            sa = out_a;
            sb = out_b;
            mode_in = 1'b0;
        end
        @(posedge clk);
        op_s <= ob;
        @(posedge clk);
        op_s.valid <= 1'b0;
        #1;
        chk("op_gp", {31'h0, gp}, {31'h0, op_gp});
        chk("frame_store", {31'h0, fs}, {31'h0, frame_store});
        chk("seg_a", sa, seg_a);
        chk("seg_b", sb, seg_b);
        if (fs) begin
            chk("frame_seg_a", fr_a, frame_seg_a);
            chk("frame_seg_b", fr_b, frame_seg_b);
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        eac_req_s r;
        {error_cnt, n_checks} = '0;
        {mode_in, sa, sb, out_a, out_b, base, lim, id} = '0;
        seed = 16'h003F;
        {addr, wdata, wr, rd} = '0;
        op_s = '0;
        ob = '0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`EAC_OFF_STATUS, 32'h0);
        base = 32'h4000;
        lim = 32'h7FFF;
        id = 32'h5A;
        wr_reg(`EAC_OFF_BASE, base);
        wr_reg(`EAC_OFF_LIMIT, lim);
        wr_reg(`EAC_OFF_ID, id);
        rd_chk(`EAC_OFF_BASE, base);
        rd_chk(`EAC_OFF_LIMIT, lim);
        rd_chk(`EAC_OFF_ID, id);
        rd_chk(8'h40, 32'h0);
        $display("test registers done");
        ob.seg_a_outside = 32'h0000_00A1;
        ob.seg_b_outside = 32'h0000_00B1;
        ob.tcs_seg_a = 32'h0000_0A20;
        ob.tcs_seg_b = 32'h0000_0B20;
        ob.tcs_phys = 32'h0001_1000;
        ob.ssa_phys = 32'h0001_3000;
        for (int i = 0; i < 4; i++) run_op(EAC_ENCLAVE_ENTER_OP, 4'h1 << i, 4'h1 << i);
        run_op(EAC_ENCLAVE_EXIT_OP, 4'h0, 4'h0);
        run_op(EAC_ENCLAVE_ENTER_OP, 4'h0, 4'hF);
        run_op(EAC_ENCLAVE_RESUME_OP, 4'h0, 4'h0);
        rd_chk(`EAC_OFF_STATUS, 32'h3);
        rd_chk(`EAC_OFF_TCS_PHYS, ob.tcs_phys);
        rd_chk(`EAC_OFF_SSA_PHYS, ob.ssa_phys);
        $display("test enter done");
        dir(EAC_FETCH, 32'h1000, 3'h0);
        dir(EAC_SS_LOAD, 32'h9000, 3'h0);
        dir(EAC_SS_STORE, 32'h9000, 3'h7);
        dir(EAC_FETCH, 32'h7FFE, 3'h3);
        dir(EAC_READ, 32'h7FFE, 3'h3);
        dir(EAC_WRITE, 32'h3FFE, 3'h3);
        dir(EAC_SS_STORE, 32'h5000, 3'h7);
        for (int i = 0; i < 300; i++) begin
            rand_req(r);
            acc(r, i % 4 == 0 ? 2 : 0);
        end
        $display("test inside done");
        run_op(EAC_ASYNCHRONOUS_EXIT, 4'h0, 4'h0);
        rd_chk(`EAC_OFF_STATUS, 32'h0);
        ob.frame_seg_a = fr_a;
        ob.frame_seg_b = fr_b;
        ob.tcs_seg_a = 32'h0000_0C30;
        ob.seg_a_outside = 32'h0000_00A2;
        run_op(EAC_ENCLAVE_RESUME_OP, 4'h0, 4'h0);
        run_op(EAC_ENCLAVE_EXIT_OP, 4'h0, 4'h0);
        run_op(EAC_ASYNCHRONOUS_EXIT, 4'h0, 4'h0);
        rd_chk(`EAC_OFF_STATUS, 32'h0);
        $display("test exit done");
        for (int i = 0; i < 40; i++) begin
            rand_req(r);
            acc(r, 0);
        end
        $display("test outside done");
        for (int i = 0; i < 4; i++) begin
            ob.page_idx = 3'(i + 4);
            ob.ctrl_phys = 32'h0002_0000 + 32'(i) * 32'h1000;
            run_op(eac_op_e'(4'(5 + i)), 4'h0, 4'h0);
            wr_reg(`EAC_OFF_BIND_SEL, 32'(i + 4));
            rd_chk(`EAC_OFF_BIND_PHYS, ob.ctrl_phys);
            rd_chk(`EAC_OFF_STATUS, 32'h4);
            run_op(eac_op_e'(4'(9 + i % 2)), 4'h0, 4'h0);
            rd_chk(`EAC_OFF_STATUS, 32'h0);
        end
        $display("test binding done");
        final_report;
    end

    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        $display("[ERR] run expected end seen hang");
        final_report;
    end
endmodule
